// ==== rtl/csc_pkg.sv ====
// csc_pkg: register map, field positions, reset values and timing for the
// charger status and control pin block.
// assumes a single 10 MHz system clock and an AHB-Lite register bus.
package csc_pkg;

   // clock and alert pulse timing
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned ALERT_PULSE_US  = 256;
   localparam int unsigned ALERT_CYCLES    = (ALERT_PULSE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned ALERT_CNT_W     = 12;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_LIMIT   = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
   localparam logic [7:0] OFS_EVENT   = 8'h14;

   // control register field positions
   localparam int unsigned CTL_PHASE_OFF   = 0;
   localparam int unsigned CTL_PHASE_A_ON  = 1;
   localparam int unsigned CTL_PHASE_B_ON  = 2;
   localparam int unsigned CTL_GOOD_OFF    = 3;
   localparam int unsigned CTL_GOOD_ON     = 4;
   localparam int unsigned CTL_PERMIT      = 5;
   localparam int unsigned CTL_ALLOW_OFF   = 6;
   localparam int unsigned CTL_ALLOW_ON    = 7;
   localparam int unsigned CTL_LIMIT_PIN   = 8;
   localparam int unsigned CTL_W           = 9;
   localparam logic [CTL_W-1:0] CTL_RESET  = 9'h121;

   // charge limit code width and reset value
   localparam int unsigned LIM_W           = 8;
   localparam logic [LIM_W-1:0] LIM_RESET  = 8'hff;

   // interrupt status bits
   localparam int unsigned IRQ_STATE_CHG   = 0;
   localparam int unsigned IRQ_GOOD_CHG    = 1;
   localparam int unsigned IRQ_TEMP_FAULT  = 2;
   localparam int unsigned IRQ_SW_EVENT    = 3;
   localparam int unsigned IRQ_W           = 4;
   localparam logic [IRQ_W-1:0] IRQ_RESET  = 4'h0;

   // status register field positions
   localparam int unsigned ST_CHARGING     = 0;
   localparam int unsigned ST_IN_WINDOW    = 1;
   localparam int unsigned ST_TEMP_OK      = 2;
   localparam int unsigned ST_ALERT        = 3;
   localparam int unsigned ST_PHASE_LO     = 4;
   localparam int unsigned ST_LIMIT_LO     = 8;

   // ahb transfer type
   localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;

   typedef enum logic [1:0] {
      CSC_ALERT_IDLE  = 2'b00,
      CSC_ALERT_PULSE = 2'b01
   } csc_alert_t;

   // analog-side status bundle
   typedef struct packed {
      logic       in_window;
      logic       temp_ok;
      logic [1:0] phase;
   } csc_sense_t;

endpackage

// ==== rtl/csc_pins.sv ====
// csc_pins: status and control pin logic of the charger with an AHB-Lite
// register slave, alert pulse generator and masked level interrupt.
// assumes all inputs synchronous to clk_sys; pads resolve open drain.
//
// Summary of operation
// - status change gives one 256 us low alert
// - phase_outputs_off stops state on phase pins
// - disabled phase pin a follows manual bit
// - disabled phase pin b follows manual bit
// - input_good_n low while voltage in window
// - good_output_off stops window drive of input_good_n
// - disabled input_good_n follows manual bit
// - charge needs permit and allow pin low
// - allow_input_off ignores allow pin for charging
// - disabled allow pin is manual indicator output
// - thermistor fault suspends charging until back
// - limit is smaller of pin and register
// - limit_pin_use low applies register limit only
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module csc_pins
   import csc_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   // ahb-lite slave
   input  wire logic                      hsel,
   input  wire logic [7:0]                haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic                      hready,
   input  wire logic [31:0]               hwdata,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // analog-side status
   input  wire csc_pkg::csc_sense_t       sense,
   input  wire logic [csc_pkg::LIM_W-1:0] charge_limit_pin,
   // charge control results
   output logic                           charge_enable,
   output logic      [csc_pkg::LIM_W-1:0] charge_limit,
   // open drain pins: output value and enable
   output logic                           alert_n_o,
   output logic                           alert_n_oe,
   output logic                           charge_phase_out_a_o,
   output logic                           charge_phase_out_a_oe,
   output logic                           charge_phase_out_b_o,
   output logic                           charge_phase_out_b_oe,
   output logic                           input_good_n_o,
   output logic                           input_good_n_oe,
   // allow pin, two-way
   input  wire logic                      charge_allow_n_i,
   output logic                           charge_allow_n_o,
   output logic                           charge_allow_n_oe,
   // interrupt
   output logic                           irq
);
   import csc_pkg::*;

   logic [CTL_W-1:0]  ctrl;
   logic [LIM_W-1:0]  charge_limit_setting;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;
   logic              wr_pend;
   logic [7:0]        wr_addr;
   logic [IRQ_W-1:0]  next_irq_status;
   logic [IRQ_W-1:0]  events;
   logic              sw_event;
   csc_sense_t        sense_q;
   logic              chg_q;
   logic              primed;
   csc_alert_t        alert_state;
   logic [ALERT_CNT_W-1:0] alert_cnt;

   logic phase_outputs_off, phase_a_manual_on, phase_b_manual_on;
   logic good_output_off, good_pin_manual_on, charge_permit;
   logic allow_input_off, allow_pin_manual_on, limit_pin_use;
   assign phase_outputs_off   = ctrl[CTL_PHASE_OFF];
   assign phase_a_manual_on   = ctrl[CTL_PHASE_A_ON];
   assign phase_b_manual_on   = ctrl[CTL_PHASE_B_ON];
   assign good_output_off     = ctrl[CTL_GOOD_OFF];
   assign good_pin_manual_on  = ctrl[CTL_GOOD_ON];
   assign charge_permit       = ctrl[CTL_PERMIT];
   assign allow_input_off     = ctrl[CTL_ALLOW_OFF];
   assign allow_pin_manual_on = ctrl[CTL_ALLOW_ON];
   assign limit_pin_use       = ctrl[CTL_LIMIT_PIN];

   function automatic logic [LIM_W-1:0] min_lim(input logic [LIM_W-1:0] a,
                                                 input logic [LIM_W-1:0] b);
      min_lim = (a < b) ? a : b;
   endfunction

   // ---------------- bus slave: zero wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && hwrite && (htrans == HTRANS_NONSEQ);
         wr_addr <= haddr;
      end
   end

   // read data registered in the address phase, stands in the data phase
   // limitation: a read right behind a write to the same register sees the old value
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && !hwrite && htrans == HTRANS_NONSEQ) begin
         case (haddr)
            OFS_CTRL:    hrdata <= {23'h0, ctrl};
            OFS_LIMIT:   hrdata <= {24'h0, charge_limit_setting};
            OFS_STATUS:  hrdata <= {16'h0, charge_limit, 2'h0, sense_q.phase,
                                    alert_state == CSC_ALERT_PULSE,
                                    sense_q.temp_ok, sense_q.in_window, chg_q};
            OFS_IRQ_ST:  hrdata <= {28'h0, irq_status};
            OFS_IRQ_MSK: hrdata <= {28'h0, irq_mask};
            default:     hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl                 <= CTL_RESET;
         charge_limit_setting <= LIM_RESET;
         irq_mask             <= IRQ_RESET;
      end else if (wr_pend) begin
         if (wr_addr == OFS_CTRL)    ctrl                 <= hwdata[CTL_W-1:0];
         if (wr_addr == OFS_LIMIT)   charge_limit_setting <= hwdata[LIM_W-1:0];
         if (wr_addr == OFS_IRQ_MSK) irq_mask             <= hwdata[IRQ_W-1:0];
      end
   end

   assign sw_event = wr_pend && (wr_addr == OFS_EVENT) && hwdata[0];

   // ---------------- charge decision and limit
   always_comb begin
      charge_enable = charge_permit && sense.temp_ok
                      && (allow_input_off || !charge_allow_n_i);
      charge_limit  = limit_pin_use
                      ? min_lim(charge_limit_pin, charge_limit_setting)
                      : charge_limit_setting;
   end

   // ---------------- event detection; set wins over write-one clear
   // history is empty after reset; no change events until it holds a sample,
   // else the reset values would look like a change and fire a false alert
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sense_q <= '0;
         chg_q   <= 1'b0;
         primed  <= 1'b0;
      end else begin
         sense_q <= sense;
         chg_q   <= charge_enable;
         primed  <= 1'b1;
      end
   end

   always_comb begin
      events = '0;
      events[IRQ_STATE_CHG]  = primed && ((sense.phase != sense_q.phase)
                                          || (charge_enable != chg_q));
      events[IRQ_GOOD_CHG]   = primed && (sense.in_window != sense_q.in_window);
      events[IRQ_TEMP_FAULT] = primed && sense_q.temp_ok && !sense.temp_ok;
      events[IRQ_SW_EVENT]   = sw_event;
      next_irq_status = irq_status;
      if (wr_pend && wr_addr == OFS_IRQ_ST)
         next_irq_status = irq_status & ~hwdata[IRQ_W-1:0];
      next_irq_status = next_irq_status | events;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) irq_status <= IRQ_RESET;
      else        irq_status <= next_irq_status;
   end

   assign irq = |(irq_status & irq_mask);

   // ---------------- alert pulse; a new event during a pulse is merged into it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alert_state <= CSC_ALERT_IDLE;
         alert_cnt   <= '0;
      end else begin
         case (alert_state)
            CSC_ALERT_IDLE: begin
               if (|events[IRQ_TEMP_FAULT:IRQ_STATE_CHG]) begin
                  alert_state <= CSC_ALERT_PULSE;
                  alert_cnt   <= ALERT_CNT_W'(ALERT_CYCLES - 1);
               end
            end
            CSC_ALERT_PULSE: begin
               if (alert_cnt == '0) alert_state <= CSC_ALERT_IDLE;
               else                 alert_cnt   <= alert_cnt - 1'b1;
            end
            default: alert_state <= CSC_ALERT_IDLE;
         endcase
      end
   end

   // ---------------- open drain pins: value always low, enable pulls
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alert_n_oe            <= 1'b0;
         charge_phase_out_a_oe <= 1'b0;
         charge_phase_out_b_oe <= 1'b0;
         input_good_n_oe       <= 1'b0;
         charge_allow_n_oe     <= 1'b0;
      end else begin
         alert_n_oe            <= alert_state == CSC_ALERT_PULSE;
         charge_phase_out_a_oe <= phase_outputs_off ? phase_a_manual_on
                                                    : sense.phase[0];
         charge_phase_out_b_oe <= phase_outputs_off ? phase_b_manual_on
                                                    : sense.phase[1];
         input_good_n_oe       <= good_output_off ? good_pin_manual_on
                                                  : sense.in_window;
         charge_allow_n_oe     <= allow_input_off && allow_pin_manual_on;
      end
   end

   // never driven high
   assign alert_n_o            = 1'b0;
   assign charge_phase_out_a_o = 1'b0;
   assign charge_phase_out_b_o = 1'b0;
   assign input_good_n_o       = 1'b0;
   assign charge_allow_n_o     = 1'b0;

   // ---------------- assertions
   // run length of the alert pull; too long for a plain delay, so counted
   logic [ALERT_CNT_W-1:0] alert_run;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)          alert_run <= '0;
      else if (alert_n_oe) alert_run <= alert_run + 1'b1;
      else                 alert_run <= '0;
   end

   sequence s_alert_start;
      (alert_state == CSC_ALERT_IDLE) && (|events[IRQ_TEMP_FAULT:IRQ_STATE_CHG]);
   endsequence

   a_alert_pulse_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_alert_start |-> ##2 alert_n_oe)
      else $error("alert did not start");
   a_alert_pulse_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(alert_n_oe) |-> alert_run == ALERT_CNT_W'(ALERT_CYCLES))
      else $error("alert pulse wrong length");
   a_alert_pulse_max: assert property (@(posedge clk_sys) disable iff (!rst_n)
      alert_n_oe |-> alert_run < ALERT_CNT_W'(ALERT_CYCLES))
      else $error("alert pulse too long");
   a_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      events[IRQ_STATE_CHG] |=> irq_status[IRQ_STATE_CHG])
      else $error("state change not latched");
   a_phase_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !phase_outputs_off |=> charge_phase_out_a_oe == $past(sense.phase[0])
                             && charge_phase_out_b_oe == $past(sense.phase[1]))
      else $error("phase pins not showing state");
   a_phase_manual: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_outputs_off |=> charge_phase_out_a_oe == $past(phase_a_manual_on))
      else $error("phase a not manual");
   a_phase_b_manual: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_outputs_off |=> charge_phase_out_b_oe == $past(phase_b_manual_on))
      else $error("phase b not manual");
   a_good_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !good_output_off |=> input_good_n_oe == $past(sense.in_window))
      else $error("good pin wrong");
   a_good_manual: assert property (@(posedge clk_sys) disable iff (!rst_n)
      good_output_off |=> input_good_n_oe == $past(good_pin_manual_on))
      else $error("good manual wrong");
   a_charge_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      charge_enable |-> charge_permit && sense.temp_ok
                        && (allow_input_off || !charge_allow_n_i))
      else $error("charge enabled wrongly");
   a_limit_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
      limit_pin_use |-> charge_limit <= charge_limit_pin
                        && charge_limit <= charge_limit_setting)
      else $error("limit not minimum");
   a_allow_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !allow_input_off |=> !charge_allow_n_oe)
      else $error("allow pin driven while input");
   a_allow_indicator: assert property (@(posedge clk_sys) disable iff (!rst_n)
      allow_input_off && allow_pin_manual_on |=> charge_allow_n_oe)
      else $error("allow indicator not pulled");
   a_allow_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      allow_input_off && charge_permit && sense.temp_ok |-> charge_enable)
      else $error("allow pin not ignored");
   a_charge_suspend: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !sense.temp_ok |-> !charge_enable)
      else $error("charging during temp fault");
   a_limit_reg_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !limit_pin_use |-> charge_limit == charge_limit_setting)
      else $error("limit pin not ignored");
endmodule

// ==== testbench/csc_host_model.sv ====
// csc_host_model: host side of the open-drain status lines with pull-ups,
// and the party that holds the charge-allow pin at a firm level.
// assumes an _oe high means the device pulls its line low.
`timescale 1ns/1ps
module csc_host_model (
   // device pin enables
   input  wire logic alert_oe,
   input  wire logic a_oe,
   input  wire logic b_oe,
   input  wire logic good_oe,
   input  wire logic allow_oe,
   // host drive of the allow pin
   input  wire logic host_allow_n,
   // resolved line levels
   output logic      alert_line,
   output logic      a_line,
   output logic      b_line,
   output logic      good_line,
   output logic      allow_line
);
   // pull-ups: a released line reads high, never a stale level
   assign alert_line = ~alert_oe;
   assign a_line     = ~a_oe;
   assign b_line     = ~b_oe;
   assign good_line  = ~good_oe;
   // host always holds a level; device pull-down wins
   assign allow_line = host_allow_n & ~allow_oe;
endmodule

// ==== testbench/testbench.sv ====
// testbench: directed scenarios for the charger pin block.
// assumes the host model resolves every open-drain line.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
   import csc_pkg::*;
   logic        clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, host_allow_n = 0;
   logic [7:0]  haddr = 0, charge_limit_pin = 8'h40, charge_limit;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 0, hrdata;
   logic        hreadyout, hresp, charge_enable, irq, hready;
   logic        al_o, al_oe, a_o, a_oe, b_o, b_oe, g_o, g_oe, w_o, w_oe;
   logic        alert_line, a_line, b_line, good_line, allow_line;
   csc_sense_t  sense = '{in_window: 1'b0, temp_ok: 1'b1, phase: 2'b00};
   int          bad_count = 0, n_checks = 0;
   assign hready = hreadyout;
   always #50 clk_sys = ~clk_sys;
   csc_pins dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sense(sense), .charge_limit_pin(charge_limit_pin),
      .charge_enable(charge_enable), .charge_limit(charge_limit),
      .alert_n_o(al_o), .alert_n_oe(al_oe), .charge_phase_out_a_o(a_o),
      .charge_phase_out_a_oe(a_oe), .charge_phase_out_b_o(b_o),
      .charge_phase_out_b_oe(b_oe), .input_good_n_o(g_o), .input_good_n_oe(g_oe),
      .charge_allow_n_i(allow_line), .charge_allow_n_o(w_o),
      .charge_allow_n_oe(w_oe), .irq(irq));
   csc_host_model host_u (.alert_oe(al_oe), .a_oe(a_oe), .b_oe(b_oe),
      .good_oe(g_oe), .allow_oe(w_oe), .host_allow_n(host_allow_n),
      .alert_line(alert_line), .a_line(a_line), .b_line(b_line),
      .good_line(good_line), .allow_line(allow_line));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // bounded wait for hready; the slave may stretch in principle
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t bus wait timed out", $time);
         end_sim();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_sys);
      hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
      wait_rdy();
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(a, 1'b0, 32'h0, d);
   endtask
   // pins lag inputs by a register stage; let it land
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset();
      logic [31:0] r;
      rd(OFS_CTRL, r);  `CHK(r[8:0], 9'h121)
      rd(OFS_LIMIT, r); `CHK(r[7:0], 8'hff)
      rd(8'h3c, r);     `CHK(r, 32'h0)
      `CHK(hresp, 1'b0)
      `CHK(irq, 1'b0)
      `CHK(hreadyout, 1'b1)
      rd(OFS_IRQ_ST, r); `CHK(r, 32'h0)
      `CHK(alert_line, 1'b1)
   endtask
   task automatic t_alert();
      int n;
      logic [31:0] r;
      n = 0;
      wr(OFS_IRQ_ST, 32'hf);
      @(posedge clk_sys); sense.phase <= 2'b10;
      n = 0;
      do begin @(posedge clk_sys); #1; n++; end while (alert_line !== 1'b0 && n < 10);
      `CHK(n < 10, 1'b1)
      `CHK({al_o, a_o, b_o, g_o, w_o}, 5'h0)
      n = 1;
      while (n < 3000) begin @(posedge clk_sys); #1; if (alert_line !== 1'b0) break; n++; end
      `CHK(n, 2560)
      rd(OFS_IRQ_ST, r); `CHK(r[0], 1'b1)
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MSK, 32'h1); settle(); `CHK(irq, 1'b1)
      wr(OFS_IRQ_ST, 32'h1); settle(); `CHK(irq, 1'b0)
      wr(OFS_EVENT, 32'h1); wr(OFS_IRQ_MSK, 32'h8); settle(); `CHK(irq, 1'b1)
      `CHK(alert_line, 1'b1)
      wr(OFS_IRQ_ST, 32'h8); settle(); `CHK(irq, 1'b0)
   endtask
   task automatic t_phase();
      wr(OFS_CTRL, 32'h120); @(posedge clk_sys); sense.phase <= 2'b01; settle();
      `CHK({a_line, b_line}, 2'b01)
      wr(OFS_CTRL, 32'h125); settle();
      `CHK(a_line, 1'b1)
      `CHK(b_line, 1'b0)
      wr(OFS_CTRL, 32'h123); settle();
      `CHK({a_line, b_line}, 2'b01)
   endtask
   task automatic t_good();
      wr(OFS_CTRL, 32'h121); @(posedge clk_sys); sense.in_window <= 1'b1; settle();
      `CHK(good_line, 1'b0)
      @(posedge clk_sys);
      sense.in_window <= 1'b0; settle(); `CHK(good_line, 1'b1)
      @(posedge clk_sys);
      sense.in_window <= 1'b1; wr(OFS_CTRL, 32'h129); settle();
      `CHK(good_line, 1'b1)
      wr(OFS_CTRL, 32'h139); settle(); `CHK(good_line, 1'b0)
   endtask
   task automatic t_charge();
      wr(OFS_CTRL, 32'h121); settle(); `CHK(charge_enable, 1'b1)
      @(posedge clk_sys);
      host_allow_n <= 1'b1; settle(); `CHK(charge_enable, 1'b0)
      @(posedge clk_sys);
      host_allow_n <= 1'b0; wr(OFS_CTRL, 32'h101); settle();
      `CHK(charge_enable, 1'b0)
      wr(OFS_CTRL, 32'h121); sense.temp_ok <= 1'b0; settle();
      `CHK(charge_enable, 1'b0)
      @(posedge clk_sys);
      sense.temp_ok <= 1'b1; settle(); `CHK(charge_enable, 1'b1)
      @(posedge clk_sys);
      host_allow_n <= 1'b1; wr(OFS_CTRL, 32'h161); settle();
      `CHK(charge_enable, 1'b1)
      `CHK(allow_line, 1'b1)
      wr(OFS_CTRL, 32'h1e1); settle(); `CHK(allow_line, 1'b0)
   endtask
   task automatic t_limit();
      logic [31:0] r;
      wr(OFS_LIMIT, 32'h80); settle(); `CHK(charge_limit, 8'h40)
      wr(OFS_LIMIT, 32'h20); settle(); `CHK(charge_limit, 8'h20)
      @(posedge clk_sys);
      charge_limit_pin <= 8'h10; settle(); `CHK(charge_limit, 8'h10)
      wr(OFS_CTRL, 32'h021); settle(); `CHK(charge_limit, 8'h20)
      rd(OFS_STATUS, r); `CHK(r[15:8], 8'h20)
      `CHK(r[5:4], 2'b01)
      `CHK(r[2:1], 2'b11)
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_alert();
      t_phase();
      t_good();
      t_charge();
      t_limit();
      end_sim();
   end
endmodule
